// ### tb/host_port_model.sv
`timescale 1ns/1ps
`default_nettype none
module host_port_model (
   input  wire logic       sys_clk,
   output logic      [6:0] regAddr,
   output logic            regWrEn,
   output logic            regRdEn,
   output logic      [7:0] regWrData
);
   initial begin
      regAddr = 7'h00;
      regWrEn = 1'b0;
      regRdEn = 1'b0;
      regWrData = 8'h00;
   end
   // one strobe cycle, then the lines stop showing the old value
   task automatic access(input logic w, input logic [6:0] a, input logic [7:0] d);
      @(posedge sys_clk);
      regAddr <= a;
      regWrData <= d;
      regWrEn <= w;
      regRdEn <= !w;
      @(posedge sys_clk);
      regWrEn <= 1'b0;
      regRdEn <= 1'b0;
      regAddr <= ~a;
      regWrData <= ~d;
   endtask
endmodule
`default_nettype wire

// ### tb/spdif_buffers_and_datapath_routing_bench.sv
`timescale 1ns/1ps
`default_nettype none
module spdif_buffers_and_datapath_routing_bench;
   import spdif_buf_pkg::*;
   logic       sys_clk = 1'b0;
   logic       rst = 1'b1;
   logic [6:0] regAddr;
   logic       regWrEn, regRdEn, regRdValid;
   logic [7:0] regWrData, regRdData, txCsByte, txUbByte;
   logic       txProfFlag, rxProfFlag;
   route_type  route;
   logic       autoCsCopyEn = 1'b0, userAutoBufEn = 1'b0;
   logic       rxCsWrEn = 1'b0, rxUbWrEn = 1'b0, qByteWrEn = 1'b0;
   logic       qDone = 1'b0, qCrcFail = 1'b0;
   logic [4:0] rxCsIdx = 5'h00, txCsRdIdx = 5'h00;
   logic [3:0] qByteIdx = 4'h0;
   logic [7:0] rxCsData = 8'h00, rxUbAddr = 8'h00, rxUbData = 8'h00;
   logic [7:0] qByteData = 8'h00, txUbRdAddr = 8'h00;
   logic [7:0] rcs[24], tcs[24], q[10], p, d, e;
   logic [7:0] expq[$];
   int         nErrors = 0, testsRun = 0, cycles = 0;

   host_port_model host_port_model_i (.sys_clk(sys_clk), .regAddr(regAddr), .regWrEn(regWrEn),
      .regRdEn(regRdEn), .regWrData(regWrData));
   spdif_buffers_and_datapath_routing spdif_buffers_and_datapath_routing_i (.sys_clk(sys_clk), .rst(rst),
      .regAddr(regAddr), .regWrEn(regWrEn), .regRdEn(regRdEn), .regWrData(regWrData),
      .regRdData(regRdData), .regRdValid(regRdValid), .autoCsCopyEn(autoCsCopyEn),
      .userAutoBufEn(userAutoBufEn), .rxCsWrEn(rxCsWrEn), .rxCsIdx(rxCsIdx), .rxCsData(rxCsData),
      .rxUbWrEn(rxUbWrEn), .rxUbAddr(rxUbAddr), .rxUbData(rxUbData), .qByteWrEn(qByteWrEn),
      .qByteIdx(qByteIdx), .qByteData(qByteData), .qDone(qDone), .qCrcFail(qCrcFail),
      .txCsRdIdx(txCsRdIdx), .txUbRdAddr(txUbRdAddr), .txCsByte(txCsByte), .txUbByte(txUbByte),
      .txProfFlag(txProfFlag), .rxProfFlag(rxProfFlag), .route(route));

   always #2.5 sys_clk = ~sys_clk;

   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      testsRun++;
      if (seen !== exp) begin
         nErrors++;
         $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic finishTest;
      $display("checks %0d mismatches %0d", testsRun, nErrors);
      if (nErrors == 0 && testsRun > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask
   task automatic wr(input logic [6:0] a, input logic [7:0] v);
      host_port_model_i.access(1'b1, a, v);
   endtask
   task automatic rd(input logic [6:0] a, input logic [7:0] v);
      expq.push_back(v);
      host_port_model_i.access(1'b0, a, 8'h00);
   endtask
   // transmitter side lookup; ends on a falling edge with outputs settled
   task automatic peek(input logic [4:0] i, input logic [7:0] a);
      @(posedge sys_clk);
      txCsRdIdx <= i;
      txUbRdAddr <= a;
      repeat (3) @(posedge sys_clk);
      @(negedge sys_clk);
   endtask

   // answers arrive in request order, so the oldest note is the one due
   always @(negedge sys_clk) begin
      if (regRdValid === 1'b1)
         chk(16'(regRdData), expq.size() > 0 ? 16'(expq.pop_front()) : 16'hffff);
   end
   always @(posedge sys_clk) begin
      cycles++;
      if (cycles == 5000) begin
         nErrors++;
         finishTest();
      end
   end

   initial begin
      void'($urandom(32'h88e67703));
      repeat (20) @(posedge sys_clk);
      rst <= 1'b0;
      rd(7'h54, 8'h00);
      rd(7'h63, 8'h00);
      for (int i = 0; i < 24; i++) begin
         // byte 0 flag forced high so the flag checks differ from the reset value
         rcs[i] = 8'($urandom) | 8'(i == 0);
         tcs[i] = 8'($urandom) | 8'(i == 0);
         @(posedge sys_clk);
         rxCsWrEn <= 1'b1;
         rxCsIdx <= 5'(i);
         rxCsData <= rcs[i];
      end
      @(posedge sys_clk);
      rxCsWrEn <= 1'b0;
      for (int i = 0; i < 24; i++) rd(7'(7'h20 + i), rcs[i]);
      rd(7'h60, 8'h00);
      @(negedge sys_clk);
      chk(16'(rxProfFlag), 16'(rcs[0][0]));
      @(posedge sys_clk);
      autoCsCopyEn <= 1'b1;
      rd(7'h20, 8'h00);
      peek(5'd5, 8'h00);
      chk(16'(txCsByte), 16'(rcs[5]));
      chk(16'(txProfFlag), 16'(rcs[0][0]));
      @(posedge sys_clk);
      autoCsCopyEn <= 1'b0;
      for (int i = 0; i < 24; i++) wr(7'(7'h38 + i), tcs[i]);
      rd(7'h3b, tcs[3]);
      for (int i = 0; i < 24; i++) begin
         peek(5'(i), 8'h00);
         chk(16'(txCsByte), 16'(tcs[i]));
         chk(16'(txProfFlag), 16'(tcs[0][0]));
      end
      p = 8'($urandom);
      d = 8'($urandom);
      e = 8'($urandom);
      @(posedge sys_clk);
      rxUbWrEn <= 1'b1;
      rxUbAddr <= p;
      rxUbData <= d;
      @(posedge sys_clk);
      rxUbWrEn <= 1'b0;
      wr(7'h50, p);
      rd(7'h50, p);
      rd(7'h51, d);
      wr(7'h51, ~d);
      rd(7'h51, d);
      @(posedge sys_clk);
      userAutoBufEn <= 1'b1;
      wr(7'h51, ~d);
      rd(7'h51, ~d);
      wr(7'h52, p + 8'h01);
      rd(7'h52, p + 8'h01);
      wr(7'h53, e);
      rd(7'h53, 8'h00);
      // rx user byte beside the tx one, so taking the tx buffer shows as a mismatch
      @(posedge sys_clk);
      rxUbWrEn <= 1'b1;
      rxUbAddr <= p + 8'h01;
      rxUbData <= ~e;
      @(posedge sys_clk);
      rxUbWrEn <= 1'b0;
      peek(5'd0, p + 8'h01);
      chk(16'(txUbByte), {8'h00, ~e});
      peek(5'd0, p);
      chk(16'(txUbByte), {8'h00, ~d});
      @(posedge sys_clk);
      userAutoBufEn <= 1'b0;
      peek(5'd0, p + 8'h01);
      chk(16'(txUbByte), 16'(e));
      for (int i = 0; i < 10; i++) begin
         q[i] = 8'($urandom);
         @(posedge sys_clk);
         qByteWrEn <= 1'b1;
         qByteIdx <= 4'(i);
         qByteData <= q[i];
      end
      @(posedge sys_clk);
      qByteWrEn <= 1'b0;
      qDone <= 1'b1;
      @(posedge sys_clk);
      qDone <= 1'b0;
      rd(7'h54, 8'h01);
      rd(7'h54, 8'h00);
      for (int i = 0; i < 10; i++) rd(7'(7'h55 + i), q[i]);
      @(posedge sys_clk);
      qCrcFail <= 1'b1;
      @(posedge sys_clk);
      qCrcFail <= 1'b0;
      rd(7'h54, 8'h02);
      rd(7'h54, 8'h00);
      for (int c = 0; c < 5; c++) begin
         wr(7'h62, {2'(c), 3'(c), 3'(c)});
         wr(7'h63, {2'b11, 3'(c), 3'(c)});
         rd(7'h62, {2'(c), 3'(c), 3'(c)});
         rd(7'h63, {2'b00, 3'(c), 3'(c)});
      end
      wr(7'h62, 8'h69);
      rd(7'h62, 8'h61);
      wr(7'h63, 8'h3e);
      rd(7'h63, 8'h24);
      @(negedge sys_clk);
      chk(16'(route), 16'({2'b01, 3'b100, 3'b001, 3'b100, 3'b100}));
      repeat (6) @(posedge sys_clk);
      chk(16'(expq.size()), 16'h0000);
      finishTest();
   end
endmodule
`default_nettype wire

// ### verilog/byte_ram.sv
`timescale 1ns/1ps
`default_nettype none
module byte_ram #(
   parameter int AW = 8
) (
   input  wire logic          sys_clk,
   input  wire logic          we,
   input  wire logic [AW-1:0] wa,
   input  wire logic [7:0]    wd,
   input  wire logic [AW-1:0] ra0,
   input  wire logic [AW-1:0] ra1,
   output logic      [7:0]    rd0,
   output logic      [7:0]    rd1
);
   // contents are not reset; software must fill a buffer before relying on it
   logic [7:0] mem [0:(1<<AW)-1];

   always_ff @(posedge sys_clk) begin
      if (we) begin
         mem[wa] <= wd;
      end
      rd0 <= mem[ra0];
      rd1 <= mem[ra1];
   end
endmodule
`default_nettype wire

// ### verilog/spdif_buf_consts.svh
`ifndef SPDIF_BUF_CONSTS_SVH
`define SPDIF_BUF_CONSTS_SVH
`define RCS_BASE    7'h20
`define RCS_LAST    7'h37
`define TCS_BASE    7'h38
`define TCS_LAST    7'h4f
`define RX_PTR_ADR  7'h50
`define RX_DAT_ADR  7'h51
`define TX_PTR_ADR  7'h52
`define TX_DAT_ADR  7'h53
`define QSTAT_ADR   7'h54
`define QBUF_BASE   7'h55
`define QBUF_LAST   7'h5e
`define ROUTE_A_ADR 7'h62
`define ROUTE_B_ADR 7'h63
`define QBUF_BYTES  4'ha
`define PROF_FLAG_BIT 0
`define LOADED_BIT  0
`define QCRC_BIT    1
`define SEL_MAX     3'h4
`define ROUTE_A_RST 8'h00
`define ROUTE_B_RST 6'h00
`endif

// ### verilog/spdif_buf_pkg.sv
`default_nettype none
package spdif_buf_pkg;
   typedef struct packed {
      logic [1:0] rateConvSourceSel;
      logic [2:0] recordPortSourceSel;
      logic [2:0] auxOutSourceSel;
      logic [2:0] playbackConvSourceSel;
      logic [2:0] transmitterSourceSel;
   } route_type;
   typedef enum logic [1:0] {
      RD_LOCAL = 2'b00,
      RD_RCS   = 2'b01,
      RD_TCS   = 2'b10,
      RD_RXUB  = 2'b11
   } rd_src_type;
endpackage
`default_nettype wire

// ### verilog/spdif_buffers_and_datapath_routing.sv
`timescale 1ns/1ps
`default_nettype none
`include "spdif_buf_consts.svh"
module spdif_buffers_and_datapath_routing
   import spdif_buf_pkg::*;
(
   input  wire logic       sys_clk,
   input  wire logic       rst,
   input  wire logic [6:0] regAddr,
   input  wire logic       regWrEn,
   input  wire logic       regRdEn,
   input  wire logic [7:0] regWrData,
   output logic      [7:0] regRdData,
   output logic            regRdValid,
   input  wire logic       autoCsCopyEn,
   input  wire logic       userAutoBufEn,
   input  wire logic       rxCsWrEn,
   input  wire logic [4:0] rxCsIdx,
   input  wire logic [7:0] rxCsData,
   input  wire logic       rxUbWrEn,
   input  wire logic [7:0] rxUbAddr,
   input  wire logic [7:0] rxUbData,
   input  wire logic       qByteWrEn,
   input  wire logic [3:0] qByteIdx,
   input  wire logic [7:0] qByteData,
   input  wire logic       qDone,
   input  wire logic       qCrcFail,
   input  wire logic [4:0] txCsRdIdx,
   input  wire logic [7:0] txUbRdAddr,
   output logic      [7:0] txCsByte,
   output logic      [7:0] txUbByte,
   output logic            txProfFlag,
   output logic            rxProfFlag,
   output route_type       route
);
   function automatic logic inRange(input logic [6:0] a, input logic [6:0] lo, input logic [6:0] hi);
      return (a >= lo) && (a <= hi);
   endfunction

   function automatic logic [4:0] offsetOf(input logic [6:0] a, input logic [6:0] base);
      logic [6:0] d;
      d = a - base;
      return d[4:0];
   endfunction

   function automatic logic selOk(input logic [2:0] code);
      return code <= `SEL_MAX;
   endfunction

   logic [7:0] rxPtr_r, rxPtr_nxt;
   logic [7:0] txPtr_r, txPtr_nxt;
   logic       subLoaded_r, subLoaded_nxt;
   logic       crcFail_r, crcFail_nxt;
   logic [7:0] qBuf_r [0:9];
   logic [7:0] qBuf_nxt [0:9];
   route_type  route_r, route_nxt;
   logic       rdPend_r, rdPend_nxt;
   rd_src_type rdSel_r, rdSel_nxt;
   logic [7:0] rdLocal_r, rdLocal_nxt;
   logic [7:0] regRdData_r, regRdData_nxt;
   logic       regRdValid_r;
   logic       copyD_r, ubAutoD_r;
   logic [7:0] txCsByte_r, txCsByte_nxt;
   logic [7:0] txUbByte_r, txUbByte_nxt;
   logic       rxProf_r, rxProf_nxt;
   logic       txProf_r, txProf_nxt;
   logic       txProfFlag_r, txProfFlag_nxt;

   logic       inRcs, inTcs, inQbuf, rdStatus;
   logic       tcsWe, txUbWe, hostUbWr, rxUbWe;
   logic [4:0] rcsHostIdx, tcsHostIdx, qIdx;
   logic [7:0] rcsRd0, rcsRd1, tcsRd0, tcsRd1;
   logic [7:0] rxUbRd0, rxUbRd1, txUbRd0;

   always_comb begin
      inRcs      = inRange(regAddr, `RCS_BASE, `RCS_LAST);
      inTcs      = inRange(regAddr, `TCS_BASE, `TCS_LAST);
      inQbuf     = inRange(regAddr, `QBUF_BASE, `QBUF_LAST);
      rcsHostIdx = offsetOf(regAddr, `RCS_BASE);
      tcsHostIdx = offsetOf(regAddr, `TCS_BASE);
      qIdx       = offsetOf(regAddr, `QBUF_BASE);
      rdStatus   = regRdEn && (regAddr == `QSTAT_ADR);
      tcsWe      = regWrEn && inTcs;
      txUbWe     = regWrEn && (regAddr == `TX_DAT_ADR);
      hostUbWr   = regWrEn && (regAddr == `RX_DAT_ADR) && userAutoBufEn;
      rxUbWe     = rxUbWrEn || hostUbWr;
   end

   byte_ram #(.AW(5)) rxCsRam (
      .sys_clk (sys_clk),
      .we      (rxCsWrEn),
      .wa      (rxCsIdx),
      .wd      (rxCsData),
      .ra0     (rcsHostIdx),
      .ra1     (txCsRdIdx),
      .rd0     (rcsRd0),
      .rd1     (rcsRd1)
   );

   byte_ram #(.AW(5)) txCsRam (
      .sys_clk (sys_clk),
      .we      (tcsWe),
      .wa      (tcsHostIdx),
      .wd      (regWrData),
      .ra0     (tcsHostIdx),
      .ra1     (txCsRdIdx),
      .rd0     (tcsRd0),
      .rd1     (tcsRd1)
   );

   // receiver wins a collision so incoming user data is never dropped
   byte_ram #(.AW(8)) rxUbRam (
      .sys_clk (sys_clk),
      .we      (rxUbWe),
      .wa      (rxUbWrEn ? rxUbAddr : rxPtr_r),
      .wd      (rxUbWrEn ? rxUbData : regWrData),
      .ra0     (rxPtr_r),
      .ra1     (txUbRdAddr),
      .rd0     (rxUbRd0),
      .rd1     (rxUbRd1)
   );

   byte_ram #(.AW(8)) txUbRam (
      .sys_clk (sys_clk),
      .we      (txUbWe),
      .wa      (txPtr_r),
      .wd      (regWrData),
      .ra0     (txUbRdAddr),
      .ra1     (txPtr_r),
      .rd0     (txUbRd0),
      .rd1     ()
   );

   always_comb begin
      rxPtr_nxt     = rxPtr_r;
      txPtr_nxt     = txPtr_r;
      route_nxt     = route_r;
      qBuf_nxt      = qBuf_r;
      rxProf_nxt    = rxProf_r;
      txProf_nxt    = txProf_r;
      rdPend_nxt    = regRdEn;
      rdSel_nxt     = RD_LOCAL;
      rdLocal_nxt   = 8'h00;
      if (regWrEn && regAddr == `RX_PTR_ADR) begin
         rxPtr_nxt = regWrData;
      end
      if (regWrEn && regAddr == `TX_PTR_ADR) begin
         txPtr_nxt = regWrData;
      end
      if (regWrEn && regAddr == `ROUTE_A_ADR) begin
         route_nxt.rateConvSourceSel = regWrData[7:6];
         if (selOk(regWrData[5:3])) begin
            route_nxt.recordPortSourceSel = regWrData[5:3];
         end
         if (selOk(regWrData[2:0])) begin
            route_nxt.auxOutSourceSel = regWrData[2:0];
         end
      end
      if (regWrEn && regAddr == `ROUTE_B_ADR) begin
         if (selOk(regWrData[5:3])) begin
            route_nxt.playbackConvSourceSel = regWrData[5:3];
         end
         if (selOk(regWrData[2:0])) begin
            route_nxt.transmitterSourceSel = regWrData[2:0];
         end
      end
      if (qByteWrEn && qByteIdx < `QBUF_BYTES) begin
         qBuf_nxt[qByteIdx] = qByteData;
      end
      if (rxCsWrEn && rxCsIdx == 5'h00) begin
         rxProf_nxt = rxCsData[`PROF_FLAG_BIT];
      end
      if (tcsWe && tcsHostIdx == 5'h00) begin
         txProf_nxt = regWrData[`PROF_FLAG_BIT];
      end
      subLoaded_nxt = qDone || (subLoaded_r && !rdStatus);
      crcFail_nxt = qCrcFail || (crcFail_r && !rdStatus);
      if (inRcs) begin
         rdSel_nxt = autoCsCopyEn ? RD_LOCAL : RD_RCS;
      end else if (inTcs) begin
         rdSel_nxt = RD_TCS;
      end else if (regAddr == `RX_DAT_ADR) begin
         rdSel_nxt = RD_RXUB;
      end else if (inQbuf) begin
         rdLocal_nxt = qBuf_r[qIdx[3:0]];
      end else begin
         unique case (regAddr)
            `RX_PTR_ADR:  rdLocal_nxt = rxPtr_r;
            `TX_PTR_ADR:  rdLocal_nxt = txPtr_r;
            `QSTAT_ADR:   rdLocal_nxt = {6'h00, crcFail_r, subLoaded_r};
            `ROUTE_A_ADR: rdLocal_nxt = {route_r.rateConvSourceSel, route_r.recordPortSourceSel,
                                         route_r.auxOutSourceSel};
            `ROUTE_B_ADR: rdLocal_nxt = {2'h0, route_r.playbackConvSourceSel,
                                         route_r.transmitterSourceSel};
            default:      rdLocal_nxt = 8'h00;
         endcase
      end
      unique case (rdSel_r)
         RD_LOCAL: regRdData_nxt = rdLocal_r;
         RD_RCS:   regRdData_nxt = rcsRd0;
         RD_TCS:   regRdData_nxt = tcsRd0;
         RD_RXUB:  regRdData_nxt = rxUbRd0;
      endcase
      if (!rdPend_r) begin
         regRdData_nxt = regRdData_r;
      end
      txCsByte_nxt  = copyD_r ? rcsRd1 : tcsRd1;
      txProfFlag_nxt = autoCsCopyEn ? rxProf_r : txProf_r;
      txUbByte_nxt  = ubAutoD_r ? rxUbRd1 : txUbRd0;
   end

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         rxPtr_r      <= 8'h00;
         txPtr_r      <= 8'h00;
         subLoaded_r  <= 1'b0;
         crcFail_r    <= 1'b0;
         route_r      <= {`ROUTE_A_RST, `ROUTE_B_RST};
         rdPend_r     <= 1'b0;
         rdSel_r      <= RD_LOCAL;
         rdLocal_r    <= 8'h00;
         regRdData_r  <= 8'h00;
         regRdValid_r <= 1'b0;
         copyD_r      <= 1'b0;
         ubAutoD_r    <= 1'b0;
         txCsByte_r   <= 8'h00;
         txUbByte_r   <= 8'h00;
         rxProf_r     <= 1'b0;
         txProf_r     <= 1'b0;
         txProfFlag_r <= 1'b0;
         for (int i = 0; i < 10; i++) begin
            qBuf_r[i] <= 8'h00;
         end
      end else begin
         rxPtr_r      <= rxPtr_nxt;
         txPtr_r      <= txPtr_nxt;
         subLoaded_r  <= subLoaded_nxt;
         crcFail_r    <= crcFail_nxt;
         route_r      <= route_nxt;
         rdPend_r     <= rdPend_nxt;
         rdSel_r      <= rdSel_nxt;
         rdLocal_r    <= rdLocal_nxt;
         regRdData_r  <= regRdData_nxt;
         regRdValid_r <= rdPend_r;
         copyD_r      <= autoCsCopyEn;
         ubAutoD_r    <= userAutoBufEn;
         txCsByte_r   <= txCsByte_nxt;
         txUbByte_r   <= txUbByte_nxt;
         rxProf_r     <= rxProf_nxt;
         txProf_r     <= txProf_nxt;
         txProfFlag_r <= txProfFlag_nxt;
         qBuf_r       <= qBuf_nxt;
      end
   end

   assign regRdData  = regRdData_r;
   assign regRdValid = regRdValid_r;
   assign txCsByte   = txCsByte_r;
   assign txUbByte   = txUbByte_r;
   assign txProfFlag = txProfFlag_r;
   assign rxProfFlag = rxProf_r;
   assign route      = route_r;

   default clocking cb @(posedge sys_clk);
   endclocking
   default disable iff (rst);

   readLatency_a: assert property (regRdEn |-> ##2 regRdValid)
      else $error("read answer not two cycles after request");
   statusClear_a: assert property (rdStatus && !qDone |=> !subLoaded_r)
      else $error("loaded flag not cleared by status read");
   loadedSet_a: assert property (qDone |=> subLoaded_r && $past(qDone))
      else $error("loaded flag not set");
   crcSticky_a: assert property (qCrcFail ##1 !rdStatus[*2] |=> crcFail_r)
      else $error("crc flag lost before read");
   rcsHidden_a: assert property (regRdEn && inRcs && autoCsCopyEn |-> ##2 regRdData == 8'h00)
      else $error("rx status visible during copy");
   statusRsvd_a: assert property (rdStatus |-> ##2 regRdData[7:2] == 6'h00)
      else $error("status reserved bits not zero");
   selReject_a: assert property (regWrEn && regAddr == `ROUTE_B_ADR && regWrData[2:0] > `SEL_MAX
                                 |=> route_r.transmitterSourceSel == $past(route_r.transmitterSourceSel))
      else $error("unused selector code accepted");
   copyPath_a: assert property ($past(copyD_r) |-> txCsByte_r == $past(rcsRd1))
      else $error("tx status not taken from rx buffer");
   rxUbLock_a: assert property (regWrEn && regAddr == `RX_DAT_ADR && !userAutoBufEn && !rxUbWrEn
                                |-> !rxUbWe)
      else $error("rx user buffer written without autobuffering");
   ptrWrite_a: assert property (regWrEn && regAddr == `TX_PTR_ADR |=> txPtr_r == $past(regWrData))
      else $error("tx pointer not loaded");

   subLoad_c: cover property (qDone ##[1:20] rdStatus);
   rxUbRead_c: cover property (regRdEn && regAddr == `RX_DAT_ADR ##2 regRdValid);
   routeWr_c: cover property (regWrEn && regAddr == `ROUTE_A_ADR);
   copyMode_c: cover property (autoCsCopyEn [*3]);
endmodule
`default_nettype wire
